// file: core/async_memory_read_sequencer.sv
// Read cycle sequencer for asynchronous SRAM and flash devices
//
// Functional notes
// - Without extended wait a read lasts setup plus strobe plus hold cycles.
// - With extended wait, output enable stays low strobe plus 16 per wait unit.
// - Strobe-select off: chip select falls at setup start, leading output enable.
// - Strobe-select on: chip select and output enable fall and rise together.
// - Strobe-select off: chip select stays low hold cycles after enable rises.
// - Bank and address are valid from setup start.
// - Bank and address stay stable through the hold cycles.
// - Without extended wait output enable is low exactly strobe cycles.
// - Each extended wait unit lengthens the read by 16 cycles.
// - Wait deadline counts nominal strobe cycles, never inserted wait cycles.
// - All phases are timed in whole system clock cycles.
// - Setup, strobe, hold and turnaround counts come from configuration inputs.
// - Extended waiting stops at a programmable limit and flags a timeout.
`timescale 1ns/100ps
`default_nettype none
`include "async_read_regs.svh"
module async_memory_read_sequencer (
    input wire logic clock_in,                                 // System clock, 125 MHz
    input wire logic sys_rst_in,                               // Synchronous reset, active high
    input wire logic read_req_in,                              // Read request, taken when idle
    input wire logic [`ADDR_W-1:0] read_addr_in,               // Read word address
    input wire logic [`BANK_W-1:0] read_bank_in,               // Read bank select
    input wire logic [`CS_SEL_W-1:0] chip_sel_in,              // Which chip select to use
    input wire logic strobe_select_in,                         // Strobe-select mode
    input wire logic extended_wait_enable_in,                  // Honour the wait pin
    input wire logic [`SETUP_W-1:0] read_setup_cycles_in,      // Setup length
    input wire logic [`STROBE_W-1:0] read_strobe_cycles_in,    // Strobe length
    input wire logic [`HOLD_W-1:0] read_hold_cycles_in,        // Hold length
    input wire logic [`TURN_W-1:0] turnaround_cycles_in,       // Turnaround length
    input wire logic [`MAX_WAIT_W-1:0] max_wait_limit_in,      // Wait unit limit
    input wire logic external_wait_input_in,                   // Wait pin, active high
    input wire logic [`DATA_W-1:0] memory_data_bus_in,         // Read data from memory
    output logic [`CS_NUM-1:0] async_chip_select_n_out,        // Chip selects, active low
    output logic output_enable_n_out,                          // Output enable, active low
    output logic [`BANK_W-1:0] bank_select_out,                // Bank select lines
    output logic [`ADDR_W-1:0] addr_out,                       // Address lines
    output logic [`DATA_W-1:0] read_data_out,                  // Captured read data
    output logic read_done_out,                                // Data valid pulse
    output logic read_busy_out,                                // Sequencer busy
    output logic wait_timeout_out,                             // Wait limit hit this read
    output logic [`MAX_WAIT_W-1:0] extended_wait_count_out     // Wait units this read
);
    import async_read_pkg::*;

    // Zero-length setup, strobe and hold phases are stretched to one cycle so each is visible
    function automatic logic [`COUNT_W-1:0] clamp_count(input logic [`COUNT_W-1:0] v);
        clamp_count = (v == `COUNT_ZERO) ? `COUNT_ONE : v;
    endfunction : clamp_count

    seq_state_t state;
    seq_state_t next_state;
    logic [`COUNT_W-1:0] cnt;
    logic [`COUNT_W-1:0] next_cnt;
    logic [3:0] ext_cnt;
    logic [`COUNT_W-1:0] strobe_q;
    logic [`COUNT_W-1:0] hold_q;
    logic [`COUNT_W-1:0] turn_q;
    logic [`MAX_WAIT_W-1:0] max_q;
    logic [`CS_SEL_W-1:0] cs_q;
    logic ss_q;
    logic ew_q;
    logic wait_pending;
    logic wait_level;

    wire take = (state == ST_IDLE) && read_req_in;
    wire last = (cnt == `COUNT_ONE);
    wire unit_end = (state == ST_EXT) && (ext_cnt == `WAIT_UNIT_LAST);
    wire [`MAX_WAIT_W-1:0] ewc_inc = extended_wait_count_out + 8'h01;
    wire wait_more = wait_level && (ewc_inc < max_q);
    wire go_ext = wait_pending && ew_q;
    // Filtered level lags the pin by two cycles, so the arming window closes two cycles later
    wire arm_window = cnt >= (`WAIT_SETUP_CYCLES - `COUNT_W'(`WAIT_MIN_PULSE_CYCLES));
    wire next_ss = take ? strobe_select_in : ss_q;
    wire [`CS_SEL_W-1:0] next_cs = take ? chip_sel_in : cs_q;
    wire next_oe_low = (next_state == ST_STROBE) || (next_state == ST_EXT);
    wire next_frame = (next_state == ST_SETUP) || next_oe_low || (next_state == ST_HOLD);
    wire next_cs_low = next_ss ? next_oe_low : next_frame;
    wire [`CS_NUM-1:0] cs_onehot = `CS_NUM'(1) << next_cs;
    wire capture = ((state == ST_STROBE) || (state == ST_EXT)) && (next_state == ST_HOLD);
    wire [`COUNT_W-1:0] setup_len = clamp_count(`COUNT_W'(read_setup_cycles_in));

    wait_sampler u_wait_sampler (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .raw_in(external_wait_input_in),
        .level_out(wait_level)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (last) begin
                    next_state = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (last) begin
                    next_state = go_ext ? ST_EXT : ST_HOLD;
                end
            end
            ST_EXT: begin
                if (unit_end) begin
                    next_state = wait_more ? ST_EXT : ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (last) begin
                    next_state = (turn_q == `COUNT_ZERO) ? ST_IDLE : ST_TURN;
                end
            end
            ST_TURN: begin
                if (last) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // Each phase loads its own length on entry; wait units leave cnt frozen
    always_comb begin
        next_cnt = cnt;
        if (take) begin
            next_cnt = setup_len;
        end else if (state != next_state) begin
            unique case (next_state)
                ST_STROBE: next_cnt = strobe_q;
                ST_HOLD: next_cnt = hold_q;
                ST_TURN: next_cnt = turn_q;
                ST_IDLE: next_cnt = `COUNT_ZERO;
                ST_SETUP: next_cnt = setup_len;
                ST_EXT: next_cnt = cnt;
            endcase
        end else if (state != ST_EXT && state != ST_IDLE) begin
            next_cnt = cnt - `COUNT_ONE;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
            cnt <= `COUNT_ZERO;
            ext_cnt <= 4'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            ext_cnt <= (state == ST_EXT) ? ext_cnt + 4'h1 : 4'h0;
        end
    end

    // Configuration is frozen per read so software changes never tear a cycle
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            strobe_q <= `COUNT_ONE;
            hold_q <= `COUNT_ONE;
            turn_q <= `COUNT_ZERO;
            max_q <= 8'h00;
            cs_q <= 2'h0;
            ss_q <= 1'b0;
            ew_q <= 1'b0;
        end else if (take) begin
            strobe_q <= clamp_count(`COUNT_W'(read_strobe_cycles_in));
            hold_q <= clamp_count(`COUNT_W'(read_hold_cycles_in));
            turn_q <= `COUNT_W'(turnaround_cycles_in);
            max_q <= max_wait_limit_in;
            cs_q <= chip_sel_in;
            ss_q <= strobe_select_in;
            ew_q <= extended_wait_enable_in;
        end
    end

    // Deadline measured on the nominal strobe count only
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wait_pending <= 1'b0;
        end else if (state == ST_STROBE && wait_level && arm_window) begin
            wait_pending <= 1'b1;
        end else if (take) begin
            wait_pending <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            extended_wait_count_out <= 8'h00;
            wait_timeout_out <= 1'b0;
        end else if (take) begin
            extended_wait_count_out <= 8'h00;
            wait_timeout_out <= 1'b0;
        end else if (unit_end) begin
            extended_wait_count_out <= ewc_inc;
            wait_timeout_out <= wait_level && !wait_more;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            async_chip_select_n_out <= `CS_IDLE;
            output_enable_n_out <= 1'b1;
            read_busy_out <= 1'b0;
        end else begin
            async_chip_select_n_out <= next_cs_low ? ~cs_onehot : `CS_IDLE;
            output_enable_n_out <= !next_oe_low;
            read_busy_out <= (next_state != ST_IDLE);
        end
    end

    // Address stays put until the next read, covering setup and hold edges
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            addr_out <= `ADDR_W'(0);
            bank_select_out <= 2'h0;
        end else if (take) begin
            addr_out <= read_addr_in;
            bank_select_out <= read_bank_in;
        end
    end

    // Data sampled in the last low cycle of output enable
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            read_data_out <= 16'h0000;
            read_done_out <= 1'b0;
        end else begin
            read_done_out <= capture;
            if (capture) begin
                read_data_out <= memory_data_bus_in;
            end
        end
    end
endmodule : async_memory_read_sequencer
`default_nettype wire

// file: core/async_read_pkg.sv
// Types shared by the asynchronous read sequencer
package async_read_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_SETUP = 6'b000010,
        ST_STROBE = 6'b000100,
        ST_EXT = 6'b001000,
        ST_HOLD = 6'b010000,
        ST_TURN = 6'b100000
    } seq_state_t;
endpackage : async_read_pkg

// file: core/async_read_regs.svh
// Field widths, fixed codes and timing counts for the asynchronous read sequencer
`ifndef ASYNC_READ_REGS_SVH
`define ASYNC_READ_REGS_SVH

`define CLK_PERIOD_NS 8
`define SETUP_W 4
`define STROBE_W 6
`define HOLD_W 3
`define TURN_W 2
`define MAX_WAIT_W 8
`define COUNT_W 8
`define ADDR_W 21
`define BANK_W 2
`define DATA_W 16
`define CS_SEL_W 2
`define CS_NUM 4
`define WAIT_UNIT_CYCLES 16
`define WAIT_UNIT_LAST 4'hf
`define WAIT_SETUP_CYCLES 8'h04
`define WAIT_MIN_PULSE_CYCLES 2
`define COUNT_ONE 8'h01
`define COUNT_ZERO 8'h00
`define CS_IDLE 4'hf

`endif

// file: core/wait_sampler.sv
// Filter that accepts a wait level only after two equal samples
`timescale 1ns/100ps
`default_nettype none
module wait_sampler (
    input wire logic clock_in,     // System clock
    input wire logic sys_rst_in,   // Synchronous reset, active high
    input wire logic raw_in,       // Wait pin, active high
    output logic level_out         // Filtered wait level
);
    logic sample;

    // Wait levels last at least two cycles, so a one-cycle glitch is dropped
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            sample <= 1'b0;
            level_out <= 1'b0;
        end else begin
            sample <= raw_in;
            if (raw_in == sample) begin
                level_out <= sample;
            end
        end
    end
endmodule : wait_sampler
`default_nettype wire

// file: dv/async_memory_model.sv
// Behavioural asynchronous memory with a commanded wait pin
`timescale 1ns/100ps
`default_nettype none
module async_memory_model (
    input wire logic clock_in, // Clock
    input wire logic [3:0] cs_n_in, // Selects
    input wire logic oe_n_in, // Enable
    input wire logic [20:0] addr_in, // Address
    input wire logic [7:0] dly_in, // Select to wait
    input wire logic [7:0] len_in, // Wait length
    output logic wait_out, // Wait pin
    output logic [15:0] data_out // Data
);
    logic [7:0] age = 8'h00;
    logic [15:0] junk = 16'h1234;
    always_ff @(posedge clock_in) begin
        junk <= junk + 16'h3c3d;
        age <= (cs_n_in == 4'hf) ? 8'h00 : age + 8'h01;
    end
    // Lengths below two are never sent
    assign wait_out = cs_n_in != 4'hf && len_in > 8'h01 && age >= dly_in
        && age < dly_in + len_in;
    // Undriven bus keeps changing
    assign data_out = oe_n_in ? junk : addr_in[15:0] ^ 16'h5a5a;
endmodule : async_memory_model
`default_nettype wire

// file: dv/async_memory_read_sequencer_tb.sv
// Self-checking bench for the asynchronous read sequencer
`timescale 1ns/100ps
`default_nettype none
`include "async_read_regs.svh"
module async_memory_read_sequencer_tb;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic read_req_in = 1'b0;
    logic [`ADDR_W-1:0] read_addr_in = '0, addr_out;
    logic [`BANK_W-1:0] read_bank_in = '0, bank_select_out;
    logic [`CS_SEL_W-1:0] chip_sel_in = '0;
    logic strobe_select_in = 1'b0, extended_wait_enable_in = 1'b0;
    logic [`SETUP_W-1:0] read_setup_cycles_in = '0;
    logic [`STROBE_W-1:0] read_strobe_cycles_in = '0;
    logic [`HOLD_W-1:0] read_hold_cycles_in = '0;
    logic [`TURN_W-1:0] turnaround_cycles_in = '0;
    logic [`MAX_WAIT_W-1:0] max_wait_limit_in = '0, extended_wait_count_out;
    logic external_wait_input_in, output_enable_n_out, read_done_out, read_busy_out;
    logic [`DATA_W-1:0] memory_data_bus_in, read_data_out;
    logic [`CS_NUM-1:0] async_chip_select_n_out;
    logic wait_timeout_out;
    logic [7:0] dly = 8'h00, len = 8'h00;
    int n_mismatch = 0, cmp_count = 0;
    async_memory_read_sequencer u_async_memory_read_sequencer (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .read_req_in(read_req_in),
        .read_addr_in(read_addr_in),
        .read_bank_in(read_bank_in),
        .chip_sel_in(chip_sel_in),
        .strobe_select_in(strobe_select_in),
        .extended_wait_enable_in(extended_wait_enable_in),
        .read_setup_cycles_in(read_setup_cycles_in),
        .read_strobe_cycles_in(read_strobe_cycles_in),
        .read_hold_cycles_in(read_hold_cycles_in),
        .turnaround_cycles_in(turnaround_cycles_in),
        .max_wait_limit_in(max_wait_limit_in),
        .external_wait_input_in(external_wait_input_in),
        .memory_data_bus_in(memory_data_bus_in),
        .async_chip_select_n_out(async_chip_select_n_out),
        .output_enable_n_out(output_enable_n_out),
        .bank_select_out(bank_select_out),
        .addr_out(addr_out),
        .read_data_out(read_data_out),
        .read_done_out(read_done_out),
        .read_busy_out(read_busy_out),
        .wait_timeout_out(wait_timeout_out),
        .extended_wait_count_out(extended_wait_count_out)
    );
    async_memory_model u_async_memory_model (.clock_in(clock_in),
        .cs_n_in(async_chip_select_n_out), .oe_n_in(output_enable_n_out),
        .addr_in(addr_out), .dly_in(dly), .len_in(len),
        .wait_out(external_wait_input_in), .data_out(memory_data_bus_in));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic complete_run;
        if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic rd(input logic [20:0] a, input logic [1:0] sel, input logic ss, ew,
        input logic [3:0] rs, input logic [5:0] st, input logic [2:0] rh,
        input logic [1:0] ta, input logic [7:0] mx, dl, ln, u, input logic to);
        int s, t, h, k, done_at = 0, cs_cnt = 0;
        logic [3:0] cs_seen = 4'hf;
        s = (rs == 0) ? 1 : rs;
        t = (st == 0) ? 1 : st;
        h = (rh == 0) ? 1 : rh;
        @(posedge clock_in);
        read_req_in <= 1'b1;
        read_addr_in <= a;
        read_bank_in <= a[1:0];
        chip_sel_in <= sel;
        strobe_select_in <= ss;
        extended_wait_enable_in <= ew;
        read_setup_cycles_in <= rs;
        read_strobe_cycles_in <= st;
        read_hold_cycles_in <= rh;
        turnaround_cycles_in <= ta;
        max_wait_limit_in <= mx;
        dly <= dl;
        len <= ln;
        @(posedge clock_in);
        read_req_in <= 1'b0;
        // Address input moves mid-read; pins must not follow
        read_addr_in <= ~a;
        for (k = 1; k < 400; k++) begin
            @(negedge clock_in);
            if (read_done_out === 1'b1) done_at = k;
            if (async_chip_select_n_out !== `CS_IDLE) begin
                cs_cnt++;
                cs_seen = async_chip_select_n_out;
            end
            if (read_busy_out !== 1'b1) break;
        end
        chk("done cycle", s + t + 1 + 16 * u, done_at);
        chk("busy cycles", s + t + h + ta + 16 * u, k - 1);
        chk("select cycles", ss ? t + 16 * u : s + t + h + 16 * u, cs_cnt);
        chk("select line", 4'hf ^ (4'h1 << sel), cs_seen);
        chk("data", a[15:0] ^ 16'h5a5a, read_data_out);
        chk("addr", a, addr_out);
        chk("bank", a[1:0], bank_select_out);
        chk("units", u, extended_wait_count_out);
        chk("timeout", to, wait_timeout_out);
    endtask : rd
    initial begin
        forever #4 clock_in = ~clock_in;
    end
    initial begin
        repeat (12) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        rd(21'h0abcd, 2'h0, 0, 0, 4'h2, 6'h03, 3'h1, 2'h1, 8'h00, 8'h00, 8'h00, 8'h00, 0);
        rd(21'h1ffff, 2'h1, 1, 0, 4'h0, 6'h00, 3'h0, 2'h0, 8'h00, 8'h00, 8'h00, 8'h00, 0);
        rd(21'h12345, 2'h2, 0, 0, 4'hf, 6'h3f, 3'h7, 2'h3, 8'h00, 8'h00, 8'h00, 8'h00, 0);
        rd(21'h00f0f, 2'h3, 1, 0, 4'h3, 6'h05, 3'h2, 2'h2, 8'h00, 8'h00, 8'h00, 8'h00, 0);
        rd(21'h05a5a, 2'h3, 0, 1, 4'h2, 6'h08, 3'h2, 2'h1, 8'h02, 8'h00, 8'hc8, 8'h02, 1);
        rd(21'h13579, 2'h0, 0, 1, 4'h2, 6'h0a, 3'h1, 2'h1, 8'h05, 8'h00, 8'h06, 8'h01, 0);
        // Wait pin rises one cycle after the deadline: no extension
        rd(21'h02468, 2'h1, 0, 1, 4'h2, 6'h08, 3'h2, 2'h1, 8'h05, 8'h07, 8'h04, 8'h00, 0);
        // Wait pin rises exactly four cycles before nominal strobe end: one unit
        rd(21'h0369c, 2'h3, 0, 1, 4'h2, 6'h08, 3'h2, 2'h1, 8'h05, 8'h06, 8'h08, 8'h01, 0);
        rd(21'h1c3c3, 2'h2, 0, 0, 4'h2, 6'h08, 3'h2, 2'h1, 8'h05, 8'h00, 8'hc8, 8'h00, 0);
        complete_run();
    end
    // Reads take a few hundred cycles; far longer means a hang
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule : async_memory_read_sequencer_tb
bind async_memory_read_sequencer async_read_checker u_async_read_checker (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .read_req_in(read_req_in),
    .strobe_select_in(strobe_select_in),
    .extended_wait_enable_in(extended_wait_enable_in),
    .read_strobe_cycles_in(read_strobe_cycles_in),
    .async_chip_select_n_out(async_chip_select_n_out),
    .output_enable_n_out(output_enable_n_out),
    .bank_select_out(bank_select_out),
    .addr_out(addr_out),
    .read_done_out(read_done_out),
    .read_busy_out(read_busy_out),
    .extended_wait_count_out(extended_wait_count_out)
);
`default_nettype wire

// file: dv/async_read_checker_assertions.sv
// Port-level assertions for the asynchronous read sequencer
`timescale 1ns/100ps
`default_nettype none
`include "async_read_regs.svh"
module async_read_checker (
    input wire logic clock_in, // Clock
    input wire logic sys_rst_in, // Reset
    input wire logic read_req_in, // Request
    input wire logic strobe_select_in, // Mode
    input wire logic extended_wait_enable_in, // Wait mode
    input wire logic [`STROBE_W-1:0] read_strobe_cycles_in, // Strobe
    input wire logic [`CS_NUM-1:0] async_chip_select_n_out, // Selects
    input wire logic output_enable_n_out, // Enable
    input wire logic [`BANK_W-1:0] bank_select_out, // Bank
    input wire logic [`ADDR_W-1:0] addr_out, // Address
    input wire logic read_done_out, // Done
    input wire logic read_busy_out, // Busy
    input wire logic [`MAX_WAIT_W-1:0] extended_wait_count_out // Units
);
    logic [11:0] low_cnt;
    wire logic oe_n = output_enable_n_out;
    wire logic ss = strobe_select_in;
    wire logic busy = read_busy_out;
    wire logic cs_on = async_chip_select_n_out != `CS_IDLE;
    wire logic [11:0] st = (read_strobe_cycles_in == 6'h00) ? 12'h001 : 12'(read_strobe_cycles_in);
    wire logic [11:0] ext = extended_wait_enable_in ? {extended_wait_count_out, 4'h0} : 12'h000;
    // Length of the current low pulse of the enable
    always_ff @(posedge clock_in) begin
        if (sys_rst_in || oe_n) low_cnt <= 12'h000;
        else low_cnt <= low_cnt + 12'h001;
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    property p_oe_len;
        $rose(oe_n) |-> low_cnt == st + ext;
    endproperty
    a_oe_len: assert property (p_oe_len) else $error("enable width");
    property p_lead;
        $fell(oe_n) && !ss |-> $past(cs_on);
    endproperty
    a_lead: assert property (p_lead) else $error("select lead");
    property p_lag;
        $rose(oe_n) && !ss |-> cs_on;
    endproperty
    a_lag: assert property (p_lag) else $error("select lag");
    property p_ss;
        ($fell(oe_n) || $rose(oe_n)) && ss |-> $changed(cs_on);
    endproperty
    a_ss: assert property (p_ss) else $error("select not with enable");
    property p_addr;
        busy && $past(busy) |-> $stable(addr_out) && $stable(bank_select_out);
    endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_take;
        !busy && read_req_in |=> busy;
    endproperty
    a_take: assert property (p_take) else $error("request not taken");
    property p_idle;
        !busy |-> !cs_on && oe_n;
    endproperty
    a_idle: assert property (p_idle) else $error("pins active when idle");
    property p_done;
        read_done_out |-> $rose(oe_n) ##1 !read_done_out;
    endproperty
    a_done: assert property (p_done) else $error("done misplaced");
endmodule : async_read_checker
`default_nettype wire
